// ### nv_access_regs.svh
// register offsets, bit positions, reset values and timing counts of the nv access block
// assumes a 100 MHz system clock and an 8-bit special function register port
`ifndef NV_ACCESS_REGS_SVH
`define NV_ACCESS_REGS_SVH

// sector select of each register
`define NV_SECTOR_ZERO      1'b0
`define NV_SECTOR_ONE       1'b1

// register offsets inside their sector
`define NV_OFS_CTRL         8'h40
`define NV_OFS_ADDR         8'h2a
`define NV_OFS_DATA         8'h2b
`define NV_OFS_IRQ          8'h2c
`define NV_OFS_PTR_ONE_HIGH 8'h03
`define NV_OFS_PTR_TWO_HIGH 8'h05

// control register fields
`define NV_CTRL_PROG_PERMIT  3
`define NV_CTRL_PROG_TRIGGER 2
`define NV_CTRL_FETCH_PERMIT 1
`define NV_CTRL_FETCH_TRIGGER 0

// interrupt register fields
`define NV_IRQ_DONE_ENABLE  0
`define NV_IRQ_MF_ENABLE    1
`define NV_IRQ_DONE_FLAG    2
`define NV_IRQ_MF_FLAG      3

// reset values
`define NV_RST_ADDR         6'h00
`define NV_RST_DATA         8'h00
`define NV_RST_CTRL         4'h0
`define NV_RST_PTR_HIGH     8'h00

// array geometry
`define NV_DEPTH            64
`define NV_ADDR_BITS        6

// read cycle time and its clock count, rounded up
`define NV_CLK_PERIOD_NS    10
`define NV_READ_TIME_NS     30
`define NV_READ_CYCLES      ((`NV_READ_TIME_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)

// write cycle length in ticks of the free-running write timer
`define NV_WRITE_TICKS      4

`endif

// ### nv_access_pkg.sv
// types shared by the nv access block
// assumes nv_access_regs.svh for all numeric constants
package nv_access_pkg;

	// sequencer of the access cycles
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_PROG  = 2'b10
	} nv_state_t;

endpackage

// ### nv_tick_sync.sv
// two-stage synchroniser for the write timer, with rising edge pulse
// assumes the timer pin is asynchronous to clk
`timescale 1ns/100ps

module nv_tick_sync
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      rise_pulse
);

	logic meta_q;
	logic sync_q;
	logic last_q;

	// two flops, then one more for edge detection
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise_pulse = sync_q & ~last_q;

endmodule

// ### nv_array.sv
// 64 by 8 non-volatile array model with fixed read latency and tick-timed writes
// assumes start pulses arrive only while the array is idle
`timescale 1ns/100ps

`include "nv_access_regs.svh"

module nv_array
#(
	parameter int DEPTH       = `NV_DEPTH,
	parameter int AW          = `NV_ADDR_BITS,
	parameter int READ_CYCLES = `NV_READ_CYCLES,
	parameter int WRITE_TICKS = `NV_WRITE_TICKS
)
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          rd_start,
	input  wire logic          wr_start,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	input  wire logic          tick,
	output logic      [7:0]    rdata,
	output logic               rd_done,
	output logic               wr_done
);

	logic [7:0]    mem [DEPTH];
	logic [AW-1:0] addr_q;
	logic [7:0]    wdata_q;
	logic [7:0]    rd_cnt_q;
	logic [7:0]    wr_cnt_q;
	logic          rd_busy_q;
	logic          wr_busy_q;
	logic          wr_last;

	assign wr_last = wr_busy_q & tick & (wr_cnt_q == 8'(WRITE_TICKS - 1));

	// latch the operands at the start of a cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			addr_q  <= '0;
			wdata_q <= 8'h00;
		end
		else if (rd_start | wr_start)
		begin
			addr_q  <= addr;
			wdata_q <= wdata;
		end
	end

	// read latency counter
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_busy_q <= 1'b0;
			rd_cnt_q  <= 8'h00;
			rd_done   <= 1'b0;
		end
		else
		begin
			rd_done <= 1'b0;
			if (rd_start)
			begin
				rd_busy_q <= 1'b1;
				rd_cnt_q  <= 8'h00;
			end
			else if (rd_busy_q)
			begin
				rd_cnt_q <= rd_cnt_q + 8'h01;
				if (rd_cnt_q == 8'(READ_CYCLES - 1))
				begin
					rd_busy_q <= 1'b0;
					rd_done   <= 1'b1;
				end
			end
		end
	end

	// write timed by the asynchronous timer ticks
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_busy_q <= 1'b0;
			wr_cnt_q  <= 8'h00;
			wr_done   <= 1'b0;
		end
		else
		begin
			wr_done <= wr_last;
			if (wr_start)
			begin
				wr_busy_q <= 1'b1;
				wr_cnt_q  <= 8'h00;
			end
			else if (wr_last)
				wr_busy_q <= 1'b0;
			else if (wr_busy_q & tick)
				wr_cnt_q <= wr_cnt_q + 8'h01;
		end
	end

	// storage cells, no reset: contents survive
	always_ff @(posedge clk)
	begin
		if (wr_last)
			mem[addr_q] <= wdata_q;
	end

	assign rdata = mem[addr_q];

endmodule

// ### nv_access_ctrl.sv
// byte-wide access controller for the on-chip non-volatile data memory
// assumes the core presents sector and offset of each register access, pointer resolution done by the core
`timescale 1ns/100ps

`include "nv_access_regs.svh"

module nv_access_ctrl
	import nv_access_pkg::*;
#(
	parameter int READ_CYCLES = `NV_READ_CYCLES,
	parameter int WRITE_TICKS = `NV_WRITE_TICKS
)
(
	input  wire logic       SYS_CLK,
	input  wire logic       RST,
	input  wire logic       SFR_WR,
	input  wire logic       SFR_RD,
	input  wire logic       SFR_SECTOR,
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic [7:0] SFR_WDATA,
	output logic      [7:0] SFR_RDATA,
	input  wire logic       PROG_TMR_TICK,
	input  wire logic       GLOBAL_IRQ_ENABLE,
	input  wire logic       STACK_FULL,
	input  wire logic       IRQ_ACK,
	output logic            IRQ_VECTOR_REQ,
	output logic      [7:0] POINTER_ONE_HIGH,
	output logic      [7:0] POINTER_TWO_HIGH,
	output logic            ACCESS_BUSY
);

	import nv_access_pkg::*;

	nv_state_t state_q;
	nv_state_t state_d;

	logic [5:0] nv_addr_reg_q;
	logic [7:0] nv_data_reg_q;
	logic       program_permit_q;
	logic       prog_trigger_q;
	logic       fetch_permit_q;
	logic       fetch_trigger_q;
	logic       done_irq_enable_q;
	logic       mf_irq_enable_q;
	logic       done_irq_flag_q;
	logic       mf_irq_flag_q;
	logic [7:0] ptr_one_high_q;
	logic [7:0] ptr_two_high_q;

	logic       sel_ctrl;
	logic       sel_addr;
	logic       sel_data;
	logic       sel_irq;
	logic       sel_p1h;
	logic       sel_p2h;
	logic       wr_ctrl;
	logic       both_triggers;
	logic       start_prog;
	logic       start_fetch;
	logic       tick;
	logic [7:0] arr_rdata;
	logic       rd_done;
	logic       wr_done;
	logic [7:0] rd_mux;

	// register decode; control only in sector 1 at 40H
	assign sel_ctrl = (SFR_SECTOR == `NV_SECTOR_ONE) && (SFR_ADDR == `NV_OFS_CTRL);
	assign sel_addr = (SFR_SECTOR == `NV_SECTOR_ZERO) && (SFR_ADDR == `NV_OFS_ADDR);
	assign sel_data = (SFR_SECTOR == `NV_SECTOR_ZERO) && (SFR_ADDR == `NV_OFS_DATA);
	assign sel_irq  = (SFR_SECTOR == `NV_SECTOR_ZERO) && (SFR_ADDR == `NV_OFS_IRQ);
	assign sel_p1h  = (SFR_SECTOR == `NV_SECTOR_ZERO) && (SFR_ADDR == `NV_OFS_PTR_ONE_HIGH);
	assign sel_p2h  = (SFR_SECTOR == `NV_SECTOR_ZERO) && (SFR_ADDR == `NV_OFS_PTR_TWO_HIGH);
	assign wr_ctrl  = SFR_WR & sel_ctrl;

	// a write asking for both triggers at once starts neither cycle; its permit bits still load
	assign both_triggers = SFR_WDATA[`NV_CTRL_PROG_TRIGGER] & SFR_WDATA[`NV_CTRL_FETCH_TRIGGER];

	// triggers honoured only if the permit was set before this write
	assign start_prog  = wr_ctrl & SFR_WDATA[`NV_CTRL_PROG_TRIGGER] & program_permit_q
		& ~both_triggers & (state_q == ST_IDLE);
	assign start_fetch = wr_ctrl & SFR_WDATA[`NV_CTRL_FETCH_TRIGGER] & fetch_permit_q
		& ~both_triggers & (state_q == ST_IDLE);

	// write timer pin is asynchronous, brought in over two flops
	nv_tick_sync u_tick_sync
	(
		.clk        (SYS_CLK),
		.rst        (RST),
		.async_in   (PROG_TMR_TICK),
		.rise_pulse (tick)
	);

	// the storage array with its own read and write timing
	nv_array
	#(
		.DEPTH       (`NV_DEPTH),
		.AW          (`NV_ADDR_BITS),
		.READ_CYCLES (READ_CYCLES),
		.WRITE_TICKS (WRITE_TICKS)
	)
	u_array
	(
		.clk      (SYS_CLK),
		.rst      (RST),
		.rd_start (start_fetch),
		.wr_start (start_prog),
		.addr     (nv_addr_reg_q),
		.wdata    (nv_data_reg_q),
		.tick     (tick),
		.rdata    (arr_rdata),
		.rd_done  (rd_done),
		.wr_done  (wr_done)
	);

	// sequencer next state
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (start_prog)
					state_d = ST_PROG;
				else if (start_fetch)
					state_d = ST_FETCH;
			end
			ST_FETCH:
			begin
				if (rd_done)
					state_d = ST_IDLE;
			end
			ST_PROG:
			begin
				if (wr_done)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	// sequencer state
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// address register, six bits
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			nv_addr_reg_q <= `NV_RST_ADDR;
		else if (SFR_WR & sel_addr)
			nv_addr_reg_q <= SFR_WDATA[5:0];
	end

	// data register; a finished read overwrites it and wins over a software write
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			nv_data_reg_q <= `NV_RST_DATA;
		else if (rd_done)
			nv_data_reg_q <= arr_rdata;
		else if (SFR_WR & sel_data)
			nv_data_reg_q <= SFR_WDATA;
	end

	// permit bits are plain read/write
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			program_permit_q <= 1'b0;
			fetch_permit_q   <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			program_permit_q <= SFR_WDATA[`NV_CTRL_PROG_PERMIT];
			fetch_permit_q   <= SFR_WDATA[`NV_CTRL_FETCH_PERMIT];
		end
	end

	// program trigger: set by an accepted start, cleared only by hardware
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			prog_trigger_q <= 1'b0;
		else if (start_prog)
			prog_trigger_q <= 1'b1;
		else if (wr_done)
			prog_trigger_q <= 1'b0;
	end

	// fetch trigger: set by an accepted start, cleared when the byte lands
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			fetch_trigger_q <= 1'b0;
		else if (start_fetch)
			fetch_trigger_q <= 1'b1;
		else if (rd_done)
			fetch_trigger_q <= 1'b0;
	end

	// interrupt enables
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			done_irq_enable_q <= 1'b0;
			mf_irq_enable_q   <= 1'b0;
		end
		else if (SFR_WR & sel_irq)
		begin
			done_irq_enable_q <= SFR_WDATA[`NV_IRQ_DONE_ENABLE];
			mf_irq_enable_q   <= SFR_WDATA[`NV_IRQ_MF_ENABLE];
		end
	end

	// done flag: set at write end wins over a software clear
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			done_irq_flag_q <= 1'b0;
		else if (wr_done)
			done_irq_flag_q <= 1'b1;
		else if (SFR_WR & sel_irq)
			done_irq_flag_q <= SFR_WDATA[`NV_IRQ_DONE_FLAG];
	end

	// mf flag: set wins over acknowledge and over software write
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			mf_irq_flag_q <= 1'b0;
		else if (wr_done)
			mf_irq_flag_q <= 1'b1;
		else if (IRQ_ACK)
			mf_irq_flag_q <= 1'b0;
		else if (SFR_WR & sel_irq)
			mf_irq_flag_q <= SFR_WDATA[`NV_IRQ_MF_FLAG];
	end

	// vector request, all enables and stack room needed
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			IRQ_VECTOR_REQ <= 1'b0;
		else
			IRQ_VECTOR_REQ <= GLOBAL_IRQ_ENABLE & done_irq_enable_q & mf_irq_enable_q
				& mf_irq_flag_q & ~STACK_FULL & ~IRQ_ACK;
	end

	// pointer high bytes, cleared at reset so sector 0 is selected
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			ptr_one_high_q <= `NV_RST_PTR_HIGH;
			ptr_two_high_q <= `NV_RST_PTR_HIGH;
		end
		else
		begin
			if (SFR_WR & sel_p1h)
				ptr_one_high_q <= SFR_WDATA;
			if (SFR_WR & sel_p2h)
				ptr_two_high_q <= SFR_WDATA;
		end
	end

	// read mux; unused bits and unmapped offsets read zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (sel_ctrl)
			rd_mux = {4'h0, program_permit_q, prog_trigger_q, fetch_permit_q, fetch_trigger_q};
		else if (sel_addr)
			rd_mux = {2'b00, nv_addr_reg_q};
		else if (sel_data)
			rd_mux = nv_data_reg_q;
		else if (sel_irq)
			rd_mux = {4'h0, mf_irq_flag_q, done_irq_flag_q, mf_irq_enable_q, done_irq_enable_q};
		else if (sel_p1h)
			rd_mux = ptr_one_high_q;
		else if (sel_p2h)
			rd_mux = ptr_two_high_q;
	end

	// registered read data and outputs
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			SFR_RDATA        <= 8'h00;
			POINTER_ONE_HIGH <= `NV_RST_PTR_HIGH;
			POINTER_TWO_HIGH <= `NV_RST_PTR_HIGH;
			ACCESS_BUSY      <= 1'b0;
		end
		else
		begin
			SFR_RDATA        <= SFR_RD ? rd_mux : 8'h00;
			POINTER_ONE_HIGH <= ptr_one_high_q;
			POINTER_TWO_HIGH <= ptr_two_high_q;
			ACCESS_BUSY      <= (state_d != ST_IDLE);
		end
	end

endmodule

// ### nv_tick_gen.sv
// free-running write timer standing in for the internal program timer
// assumes nothing of the system clock; period and phase are unrelated to it
`timescale 1ns/100ps

module nv_tick_gen
#(
	parameter real HALF_NS = 37.3
)
(
	output logic tick
);
	// square wave with an odd start offset so edges drift across the clock phase; some land on a clock edge
	initial
	begin
		tick = 1'b0;
		#3.7;
		forever #(HALF_NS) tick = ~tick;
	end
endmodule

// ### nv_access_sva.sv
// port assertions of the nv access controller
// assumes the register map of nv_access_regs.svh and a synchronous active-high reset
`timescale 1ns/100ps

`include "nv_access_regs.svh"

module nv_access_sva
#(
	parameter int READ_CYCLES = 3,
	parameter int WRITE_TICKS = 4
)
(
	input wire logic       SYS_CLK,
	input wire logic       RST,
	input wire logic       SFR_WR,
	input wire logic       SFR_RD,
	input wire logic       SFR_SECTOR,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic [7:0] SFR_RDATA,
	input wire logic       PROG_TMR_TICK,
	input wire logic       GLOBAL_IRQ_ENABLE,
	input wire logic       STACK_FULL,
	input wire logic       IRQ_ACK,
	input wire logic       IRQ_VECTOR_REQ,
	input wire logic [7:0] POINTER_ONE_HIGH,
	input wire logic [7:0] POINTER_TWO_HIGH,
	input wire logic       ACCESS_BUSY
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	// read data returns to zero outside the answer cycle
	rdata_idle_a: assert property (!$past(SFR_RD) |-> SFR_RDATA == 8'h00)
		else $error("read data not zero without a read");
	// pointer high bytes come out of reset at zero
	ptr_reset_a: assert property ($past(RST) |-> POINTER_ONE_HIGH == 8'h00 && POINTER_TWO_HIGH == 8'h00)
		else $error("pointer high byte not zero after reset");
	// pointer one follows a write to its offset; register then output copy, two cycles
	ptr_one_wr_a: assert property (SFR_WR && !SFR_SECTOR && SFR_ADDR == `NV_OFS_PTR_ONE_HIGH |-> ##2
		POINTER_ONE_HIGH == $past(SFR_WDATA, 2)) else $error("pointer one high not loaded");
	// unimplemented control bits read zero
	ctrl_upper_a: assert property ($past(SFR_RD) && $past(SFR_SECTOR) && $past(SFR_ADDR) == 8'h40 |->
		SFR_RDATA[7:4] == 4'h0) else $error("control upper bits not zero");
	// address register upper bits read zero
	addr_upper_a: assert property ($past(SFR_RD) && !$past(SFR_SECTOR) && $past(SFR_ADDR) == `NV_OFS_ADDR |->
		SFR_RDATA[7:6] == 2'b00) else $error("address upper bits not zero");
	// a cycle starts only from a control register write
	busy_cause_a: assert property ($rose(ACCESS_BUSY) |-> $past(SFR_WR) && $past(SFR_SECTOR) &&
		$past(SFR_ADDR) == 8'h40) else $error("cycle started without control write");
	// every cycle ends in bounded time
	busy_bound_a: assert property ($rose(ACCESS_BUSY) |-> ##[1:400] !ACCESS_BUSY)
		else $error("access cycle never ended");
	// vector only with global enable and free stack
	vec_gate_a: assert property (IRQ_VECTOR_REQ |-> $past(GLOBAL_IRQ_ENABLE) && !$past(STACK_FULL))
		else $error("vector request while gated");
	// servicing drops the vector request
	ack_clear_a: assert property (IRQ_ACK |=> !IRQ_VECTOR_REQ)
		else $error("vector request held after service");

	// main scenarios
	cov_cycle: cover property ($fell(ACCESS_BUSY));
	cov_vector: cover property ($rose(IRQ_VECTOR_REQ));
	cov_ack: cover property (IRQ_ACK && IRQ_VECTOR_REQ);
endmodule

bind nv_access_ctrl nv_access_sva #(.READ_CYCLES(READ_CYCLES), .WRITE_TICKS(WRITE_TICKS)) u_sva
(
	.SYS_CLK(SYS_CLK), .RST(RST), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_SECTOR(SFR_SECTOR),
	.SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .PROG_TMR_TICK(PROG_TMR_TICK),
	.GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .STACK_FULL(STACK_FULL), .IRQ_ACK(IRQ_ACK),
	.IRQ_VECTOR_REQ(IRQ_VECTOR_REQ), .POINTER_ONE_HIGH(POINTER_ONE_HIGH),
	.POINTER_TWO_HIGH(POINTER_TWO_HIGH), .ACCESS_BUSY(ACCESS_BUSY)
);

// ### tb.sv
// self-checking bench of the nv access controller through its register port
// assumes nv_access_regs.svh for the map and nv_tick_gen as the write timer
`timescale 1ns/100ps

`include "nv_access_regs.svh"

module tb;
	logic       clk;
	logic       rst;
	logic       wr;
	logic       rd;
	logic       sec;
	logic [7:0] ofs;
	logic [7:0] wdat;
	logic [7:0] rdat;
	logic       tick;
	logic       gie;
	logic       full;
	logic       ack;
	logic       vec;
	logic [7:0] p1;
	logic [7:0] p2;
	logic [7:0] rd_seen;
	logic       busy;
	int         err_count;
	int         checks_done;
	logic [5:0] at [3] = '{6'h00, 6'h3f, 6'h15};
	logic [7:0] dt [3] = '{8'h5a, 8'hc3, 8'h81};

	nv_access_ctrl uut (.SYS_CLK(clk), .RST(rst), .SFR_WR(wr), .SFR_RD(rd), .SFR_SECTOR(sec),
		.SFR_ADDR(ofs), .SFR_WDATA(wdat), .SFR_RDATA(rdat), .PROG_TMR_TICK(tick),
		.GLOBAL_IRQ_ENABLE(gie), .STACK_FULL(full), .IRQ_ACK(ack), .IRQ_VECTOR_REQ(vec),
		.POINTER_ONE_HIGH(p1), .POINTER_TWO_HIGH(p2), .ACCESS_BUSY(busy));
	nv_tick_gen u_tmr (.tick(tick));

	// system clock, 10 ns
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one strobe cycle, then one idle cycle
	task automatic reg_wr(input logic s, input logic [7:0] o, input logic [7:0] v);
		sec = s;
		ofs = o;
		wdat = v;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		@(posedge clk);
		#1;
	endtask

	// answer is taken in the cycle after the strobe edge, left in rd_seen
	task automatic reg_rd(input logic s, input logic [7:0] o);
		sec = s;
		ofs = o;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		rd_seen = rdat;
		@(posedge clk);
		#1;
	endtask

	task automatic rd_chk(input logic s, input logic [7:0] o, input logic [7:0] exp, input string what);
		reg_rd(s, o);
		check(what, rd_seen, exp);
	endtask

	// poll the control register until trigger bit b falls, at most lim reads
	task automatic wait_clear(input int b, input logic [7:0] keep, input int lim);
		int n;
		n = 0;
		do
		begin
			reg_rd(1'b1, `NV_OFS_CTRL);
			n++;
			check("poll other bits", rd_seen & ~(8'h01 << b), keep);
		end
		while (rd_seen[b] === 1'b1 && n < lim);
		check("trigger clear", {7'h00, rd_seen[b]}, 8'h00);
	endtask

	task automatic results;
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial
	begin
		#300000;
		err_count++;
		results();
	end

	// test sequence
	initial
	begin
		{rst, wr, rd, sec, ofs, wdat, gie, full, ack} = {3'b100, 1'b0, 16'h0000, 3'b000};
		err_count = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		rd_chk(1'b1, `NV_OFS_CTRL, 8'h00, "ctrl reset");
		rd_chk(1'b0, `NV_OFS_ADDR, 8'h00, "addr reset");
		rd_chk(1'b0, `NV_OFS_DATA, 8'h00, "data reset");
		check("pointer reset", p1, 8'h00);
		check("pointer two reset", p2, 8'h00);
		reg_wr(1'b0, `NV_OFS_ADDR, 8'hff);
		rd_chk(1'b0, `NV_OFS_ADDR, 8'h3f, "addr width");
		reg_wr(1'b1, 8'h41, 8'hff);
		rd_chk(1'b1, 8'h41, 8'h00, "unmapped");
		reg_wr(1'b0, `NV_OFS_PTR_ONE_HIGH, 8'h01);
		check("pointer one", p1, 8'h01);
		reg_wr(1'b0, `NV_OFS_PTR_TWO_HIGH, 8'h01);
		check("pointer two", p2, 8'h01);
		reg_wr(1'b0, `NV_OFS_IRQ, 8'h03);
		// writes with done interrupt, serviced each time
		for (int i = 0; i < 3; i++)
		begin
			reg_wr(1'b0, `NV_OFS_ADDR, {2'b00, at[i]});
			reg_wr(1'b0, `NV_OFS_DATA, dt[i]);
			gie = 1'b0;
			reg_wr(1'b1, `NV_OFS_CTRL, 8'h08);
			reg_wr(1'b1, `NV_OFS_CTRL, 8'h0c);
			check("write busy", {7'h00, busy}, 8'h01);
			gie = 1'b1;
			wait_clear(`NV_CTRL_PROG_TRIGGER, 8'h08, 300);
			rd_chk(1'b1, `NV_OFS_CTRL, 8'h08, "write end");
			rd_chk(1'b0, `NV_OFS_IRQ, 8'h0f, "done flags");
			check("vector", {7'h00, vec}, 8'h01);
			ack = 1'b1;
			@(posedge clk);
			#1;
			ack = 1'b0;
			rd_chk(1'b0, `NV_OFS_IRQ, 8'h07, "ack clears mf");
			reg_wr(1'b0, `NV_OFS_IRQ, 8'h03);
		end
		// vector gated by stack, global enable and done enable
		for (int i = 0; i < 4; i++)
		begin
			full = (i == 0);
			gie = (i != 2);
			reg_wr(1'b0, `NV_OFS_IRQ, (i == 3) ? 8'h0a : 8'h0b);
			check("vector gating", {7'h00, vec}, (i == 1) ? 8'h01 : 8'h00);
		end
		// reads back every written byte
		for (int i = 0; i < 3; i++)
		begin
			reg_wr(1'b1, `NV_OFS_CTRL, 8'h02);
			reg_wr(1'b0, `NV_OFS_ADDR, {2'b00, at[i]});
			reg_wr(1'b1, `NV_OFS_CTRL, 8'h03);
			check("read busy", {7'h00, busy}, 8'h01);
			wait_clear(`NV_CTRL_FETCH_TRIGGER, 8'h02, 4);
			rd_chk(1'b1, `NV_OFS_CTRL, 8'h02, "read end");
			rd_chk(1'b0, `NV_OFS_DATA, dt[i], "fetched");
		end
		rd_chk(1'b0, `NV_OFS_DATA, dt[2], "byte held");
		// refused triggers
		reg_wr(1'b1, `NV_OFS_CTRL, 8'h00);
		reg_wr(1'b0, `NV_OFS_DATA, 8'h77);
		reg_wr(1'b1, `NV_OFS_CTRL, 8'h04);
		check("no write", {7'h00, busy}, 8'h00);
		reg_wr(1'b1, `NV_OFS_CTRL, 8'h0c);
		check("permit same write", {7'h00, busy}, 8'h00);
		reg_wr(1'b1, `NV_OFS_CTRL, 8'h01);
		check("no read", {7'h00, busy}, 8'h00);
		rd_chk(1'b1, `NV_OFS_CTRL, 8'h00, "triggers refused");
		rd_chk(1'b0, `NV_OFS_DATA, 8'h77, "data kept");
		reg_wr(1'b1, `NV_OFS_CTRL, 8'hff);
		rd_chk(1'b1, `NV_OFS_CTRL, 8'h0a, "both triggers");
		reg_wr(1'b1, `NV_OFS_CTRL, 8'h0b);
		wait_clear(`NV_CTRL_FETCH_TRIGGER, 8'h0a, 4);
		rd_chk(1'b1, `NV_OFS_CTRL, 8'h0a, "late read end");
		rd_chk(1'b0, `NV_OFS_DATA, dt[2], "array kept");
		// reset in mid-run drops permits, pointers and data, keeps the array
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		rd_chk(1'b1, `NV_OFS_CTRL, 8'h00, "ctrl after reset");
		check("pointers after reset", p1 | p2, 8'h00);
		rd_chk(1'b0, `NV_OFS_DATA, 8'h00, "data after reset");
		reg_wr(1'b1, `NV_OFS_CTRL, 8'h02);
		reg_wr(1'b0, `NV_OFS_ADDR, {2'b00, at[0]});
		reg_wr(1'b1, `NV_OFS_CTRL, 8'h03);
		wait_clear(`NV_CTRL_FETCH_TRIGGER, 8'h02, 4);
		rd_chk(1'b0, `NV_OFS_DATA, dt[0], "array after reset");
		results();
	end
endmodule
